// ===== src/tcp_top.sv
/*
 * tcp_top: 8/16-bit timer/counter with prescaler behind a Wishbone slave.
 * Assumes one clk_i cycle per instruction cycle, a synchronous high reset,
 * a sleep level from the same clock domain and an asynchronous count pin.
 */
// Operation
// - source select clear: timer mode, one step per instruction cycle unscaled.
// - after a low byte write, no counting for two instruction cycles.
// - source select set: counter mode, steps on chosen external pin edge.
// - edge select clear counts rising edges, set counts falling edges.
// - external input synchronised first; increment follows after that delay.
// - an 8-bit prescaler exists; software cannot read or write it.
// - prescaler bypass clear routes input through prescaler, ratios 1:2 to 1:256.
// - low byte write clears prescaler count when assigned; assignment unchanged.
// - prescaler assignment may change at any time while running.
// - overflow flag sets on FFh to 00h, or FFFFh to 0000h.
// - overflow interrupt enable clear blocks the interrupt request.
// - timer stopped in sleep, so overflow never wakes the processor.
// - 16-bit mode: high byte hidden; low byte read copies it to buffer.
// - 16-bit mode: low byte write loads high byte from buffer too.
// - control bits 7..0: run, width, source, edge, bypass, three prescale.
// - reset sets control to all ones and clears the high buffer.
// - interrupt control: global 7, peripheral 6, overflow enable 5, flag 2.
`timescale 1ns/1ns
module tcp_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// core state and pin
	input  wire logic        sleep_i,
	input  wire logic        external_count_pin_i,
	// interrupt request towards the core
	output logic             overflow_irq_o
);
	import tcp_pkg::*;

	// address decode shared by read and write paths
	function automatic logic adr_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
		adr_hit = (adr == reg_adr);
	endfunction

	// registers
	tcp_bus_state_t bus_state_r;
	tcp_bus_state_t bus_state_nxt;
	logic [31:0]    rdata_r;
	logic [31:0]    rdata_nxt;
	logic [15:0]    count_r;
	logic [15:0]    count_nxt;
	logic [7:0]     high_buf_r;
	logic [7:0]     high_buf_nxt;
	logic [7:0]     ctrl_r;
	logic [7:0]     ctrl_nxt;
	logic [7:0]     intctl_r;
	logic [7:0]     intctl_nxt;
	logic [1:0]     inhibit_r;
	logic [1:0]     inhibit_nxt;

	// bus decode
	logic access;
	logic wr_stb;
	logic rd_stb;
	logic lane0;
	logic hit_low;
	logic hit_high;
	logic hit_intctl;
	logic hit_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_intctl;
	logic wr_ctrl;
	logic rd_low;
	logic [7:0] wbyte;
	logic [7:0] rbyte;

	// control fields
	logic       run_enable;
	logic       width_select;
	logic       source_select;
	logic       edge_select;
	logic       prescaler_bypass;
	logic [2:0] prescale_select;
	logic       overflow_int_enable;
	logic       overflow_flag;
	logic       global_int_enable;

	// count path
	logic       pin_edge;
	logic       src_tick;
	logic       psc_tick;
	logic       psc_clear;
	logic       step_tick;
	logic       active;
	logic       step;
	logic       wrap_8;
	logic       wrap_16;
	logic       overflow;
	logic [7:0] low_inc;
	logic [7:0] high_inc;
	logic       inhibit_idle;
	logic       psc_src;
	logic       wrap_sel;

	// wishbone slave: one wait state, ack for one cycle
	assign access = wb_cyc_i & wb_stb_i & (bus_state_r == TCP_BUS_IDLE);
	assign wr_stb = access & wb_we_i;
	assign rd_stb = access & ~wb_we_i;
	assign lane0  = wb_sel_i[0];
	assign wbyte  = wb_dat_i[7:0];

	assign hit_low    = adr_hit(wb_adr_i, TCP_ADR_LOW);
	assign hit_high   = adr_hit(wb_adr_i, TCP_ADR_HIGH);
	assign hit_intctl = adr_hit(wb_adr_i, TCP_ADR_INTCTL);
	assign hit_ctrl   = adr_hit(wb_adr_i, TCP_ADR_CTRL);

	assign wr_low    = wr_stb & lane0 & hit_low;
	assign wr_high   = wr_stb & lane0 & hit_high;
	assign wr_intctl = wr_stb & lane0 & hit_intctl;
	assign wr_ctrl   = wr_stb & lane0 & hit_ctrl;
	assign rd_low    = rd_stb & hit_low;

	always_comb begin
		case (bus_state_r)
			TCP_BUS_IDLE: begin
				bus_state_nxt = access ? TCP_BUS_ACK : TCP_BUS_IDLE;
			end
			TCP_BUS_ACK: begin
				bus_state_nxt = TCP_BUS_IDLE;
			end
			default: begin
				bus_state_nxt = TCP_BUS_IDLE;
			end
		endcase
	end

	assign wb_ack_o = (bus_state_r == TCP_BUS_ACK);

	// read mux; unmapped addresses and upper bits read as zero
	assign rbyte = hit_low    ? count_r[7:0] :
	               hit_high   ? high_buf_r   :
	               hit_intctl ? intctl_r     :
	               hit_ctrl   ? ctrl_r       : 8'h00;

	assign rdata_nxt = rd_stb ? {24'h000000, rbyte} : rdata_r;

	assign wb_dat_o = rdata_r;

	// control field taps
	assign run_enable       = ctrl_r[TCP_CTRL_RUN];
	assign width_select     = ctrl_r[TCP_CTRL_WIDTH];
	assign source_select    = ctrl_r[TCP_CTRL_SRC];
	assign edge_select      = ctrl_r[TCP_CTRL_EDGE];
	assign prescaler_bypass = ctrl_r[TCP_CTRL_BYPASS];
	assign prescale_select  = ctrl_r[TCP_CTRL_PS_MSB:TCP_CTRL_PS_LSB];

	assign global_int_enable   = intctl_r[TCP_IC_GIE];
	assign overflow_int_enable = intctl_r[TCP_IC_OVFIE];
	assign overflow_flag       = intctl_r[TCP_IC_OVFIF];

	// count source selection
	tcp_sync_edge u_sync_edge (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.pin_i     (external_count_pin_i),
		.falling_i (edge_select),
		.edge_o    (pin_edge)
	);

	// timer mode counts every instruction cycle, counter mode counts pin edges
	assign src_tick = source_select ? pin_edge : 1'b1;

	// sleep and run enable stop the source ahead of the prescaler
	assign active = run_enable & ~sleep_i;

	// prescaler clear only while it is assigned; bypass bit is not touched
	assign psc_clear = wr_low & ~prescaler_bypass;
	assign psc_src   = src_tick & active & ~prescaler_bypass;

	tcp_prescaler u_prescaler (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.tick_i      (psc_src),
		.clear_i     (psc_clear),
		.ratio_sel_i (prescale_select),
		.tick_o      (psc_tick)
	);

	// assignment read live each cycle, so it may change while running
	assign step_tick = prescaler_bypass ? (src_tick & active) : psc_tick;

	// held off right after a low byte write
	assign inhibit_idle = (inhibit_r == 2'h0);
	assign step         = step_tick & inhibit_idle & ~wr_low;

	// counter and overflow
	assign low_inc  = count_r[7:0] + 8'h01;
	assign high_inc = count_r[15:8] + 8'h01;
	assign wrap_8   = (count_r[7:0] == 8'hff);
	assign wrap_16  = wrap_8 & (count_r[15:8] == 8'hff);

	// width select set: 8-bit, clear: 16-bit
	assign wrap_sel = width_select ? wrap_8 : wrap_16;
	assign overflow = step & wrap_sel;

	always_comb begin
		count_nxt = count_r;
		if (wr_low) begin
			count_nxt[7:0] = wbyte;
			if (!width_select) begin
				count_nxt[15:8] = high_buf_r;
			end
		end else if (step) begin
			count_nxt[7:0] = low_inc;
			if (!width_select && wrap_8) begin
				count_nxt[15:8] = high_inc;
			end
		end
	end

	always_comb begin
		inhibit_nxt = inhibit_r;
		if (wr_low) begin
			inhibit_nxt = TCP_WR_INHIBIT_CYC;
		end else if (!inhibit_idle) begin
			inhibit_nxt = inhibit_r - 2'h1;
		end
	end

	// high buffer: software writes, or snapshot of the hidden high byte
	always_comb begin
		high_buf_nxt = high_buf_r;
		if (wr_high) begin
			high_buf_nxt = wbyte;
		end else if (rd_low && !width_select) begin
			high_buf_nxt = count_r[15:8];
		end
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = wbyte;
		end
	end

	// overflow sets the flag even in the cycle software clears it
	always_comb begin
		intctl_nxt = intctl_r;
		if (wr_intctl) begin
			intctl_nxt = wbyte;
		end
		if (overflow) begin
			intctl_nxt[TCP_IC_OVFIF] = 1'b1;
		end
	end

	// request only with the overflow enable and the global enable set
	assign overflow_irq_o = overflow_flag & overflow_int_enable & global_int_enable;

	// state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state_r <= TCP_BUS_IDLE;
		end else begin
			bus_state_r <= bus_state_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= {TCP_LOW_RST, TCP_LOW_RST};
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit_r <= 2'h0;
		end else begin
			inhibit_r <= inhibit_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_buf_r <= TCP_HIGH_RST;
		end else begin
			high_buf_r <= high_buf_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= TCP_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			intctl_r <= TCP_INTCTL_RST;
		end else begin
			intctl_r <= intctl_nxt;
		end
	end

endmodule

// ===== src/tcp_pkg.sv
/*
 * tcp_pkg: shared constants for the timer/counter with prescaler.
 * Assumes a 32-bit classic Wishbone register bus, one byte per word.
 */
package tcp_pkg;

	// register byte addresses
	localparam logic [7:0] TCP_ADR_LOW    = 8'h00;
	localparam logic [7:0] TCP_ADR_HIGH   = 8'h04;
	localparam logic [7:0] TCP_ADR_INTCTL = 8'h08;
	localparam logic [7:0] TCP_ADR_CTRL   = 8'h0c;

	// timer_control field positions
	localparam int TCP_CTRL_RUN    = 7;
	localparam int TCP_CTRL_WIDTH  = 6;
	localparam int TCP_CTRL_SRC    = 5;
	localparam int TCP_CTRL_EDGE   = 4;
	localparam int TCP_CTRL_BYPASS = 3;
	localparam int TCP_CTRL_PS_MSB = 2;
	localparam int TCP_CTRL_PS_LSB = 0;

	// main_interrupt_control field positions
	localparam int TCP_IC_GIE   = 7;
	localparam int TCP_IC_PEIE  = 6;
	localparam int TCP_IC_OVFIE = 5;
	localparam int TCP_IC_OVFIF = 2;

	// values after reset
	localparam logic [7:0] TCP_CTRL_RST   = 8'hff;
	localparam logic [7:0] TCP_HIGH_RST   = 8'h00;
	localparam logic [7:0] TCP_INTCTL_RST = 8'h00;
	localparam logic [7:0] TCP_LOW_RST    = 8'h00;

	// instruction cycles with counting held off after a low byte write
	localparam logic [1:0] TCP_WR_INHIBIT_CYC = 2'h2;

	// bus slave states
	typedef enum logic [0:0] {
		TCP_BUS_IDLE = 1'b0,
		TCP_BUS_ACK  = 1'b1
	} tcp_bus_state_t;

endpackage

// ===== src/tcp_sync_edge.sv
/*
 * tcp_sync_edge: two-flop synchroniser and edge picker for the count pin.
 * Assumes the pin is asynchronous to clk_i; the pulse is one clock long.
 */
`timescale 1ns/1ns
module tcp_sync_edge (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pin and edge choice
	input  wire logic pin_i,
	input  wire logic falling_i,
	// one-cycle count pulse
	output logic      edge_o
);
	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	logic edge_r;
	logic edge_nxt;

	assign edge_nxt = falling_i ? (prev_r & ~sync2_r) : (~prev_r & sync2_r);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
			edge_r  <= 1'b0;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
			edge_r  <= edge_nxt;
		end
	end

	assign edge_o = edge_r;
endmodule

// ===== src/tcp_prescaler.sv
/*
 * tcp_prescaler: hidden 8-bit prescale counter, ratio 2 to 256.
 * Assumes tick_i is a one-cycle pulse on clk_i.
 */
`timescale 1ns/1ns
module tcp_prescaler (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       tick_i,
	input  wire logic       clear_i,
	input  wire logic [2:0] ratio_sel_i,
	// divided tick
	output logic            tick_o
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] mask;
	logic       wrap;

	// ratio 2^(n+1): last count of the window has the low n+1 bits set
	assign mask    = 8'((9'h2 << ratio_sel_i) - 9'h1);
	assign wrap    = ((cnt_r & mask) == mask);
	assign tick_o  = tick_i & wrap & ~clear_i;
	assign cnt_nxt = clear_i ? 8'h00 : (tick_i ? cnt_r + 8'h01 : cnt_r);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// ===== testbench/tcp_assertions.sv
/* tcp_assertions: bus, read data and interrupt checks on tcp_top ports.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ns
module tcp_checker (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// core side
	input wire logic        sleep_i,
	input wire logic        external_count_pin_i,
	input wire logic        overflow_irq_o
);
	wire logic rq;
	assign rq = wb_cyc_i && wb_stb_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	ack_latency_a: assert property (rq && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(rq))
		else $error("ack without request");
	dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
		else $error("read data moved outside a read");
	unmapped_zero_a: assert property (
		wb_ack_o && $past(!wb_we_i && wb_adr_i[7:4] != 4'h0) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	sleep_irq_a: assert property (
		sleep_i [*4] ##1 $rose(overflow_irq_o) |-> $past(rq && wb_we_i))
		else $error("interrupt rose during sleep");
	irq_fall_a: assert property ($fell(overflow_irq_o) |-> $past(rq && wb_we_i))
		else $error("interrupt fell without a write");
endmodule
bind tcp_top tcp_checker u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
	.external_count_pin_i(external_count_pin_i), .overflow_irq_o(overflow_irq_o)
);

// ===== testbench/tcp_pulse_src.sv
/* tcp_pulse_src: pulse source on the external count pin.
   Assumes go_i is a one-cycle request; the pin idles low. */
`timescale 1ns/1ns
module tcp_pulse_src (
	// clock and request
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] half_i,
	input  wire logic [7:0] n_i,
	// pin and status
	output logic            pin_o,
	output logic            busy_o
);
	initial begin
		pin_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				// each level lasts half_i cycles; a half_i of zero gives no pulse at all
				repeat (n_i) begin
					pin_o <= 1'b1;
					repeat (half_i) @(posedge clk_i);
					pin_o <= 1'b0;
					repeat (half_i) @(posedge clk_i);
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule

// ===== testbench/tcp_bench.sv
/* tcp_bench: register-level tests of the timer/counter over Wishbone.
   Assumes tcp_pulse_src drives the count pin and the checker is bound. */
`timescale 1ns/1ns
module tcp_bench;
	logic        clk, rst, cyc, stb, we, slp, go, ack, irq, pin, busy;
	logic [7:0]  adr, v, dv;
	logic [3:0]  sel;
	logic [31:0] dwr, drd, q;
	int          fail_count, n_compared, cyc_cnt;

	tcp_top dut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
		.sleep_i(slp), .external_count_pin_i(pin), .overflow_irq_o(irq)
	);
	tcp_pulse_src u_src (
		.clk_i(clk), .go_i(go), .half_i(8'h0c), .n_i(8'h01), .pin_o(pin), .busy_o(busy)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dwr <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = drd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, 4'h1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 4'hf, 8'h00);
		check(q, {24'h0, e});
	endtask

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dwr = 32'h0;
		slp = 1'b0;
		go = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(8'h0c, 8'hff);
		rd(8'h04, 8'h00);
		wr(8'h10, 8'h5a);
		rd(8'h10, 8'h00);
		bus(1'b1, 8'h0c, 4'h0, 8'h00);
		rd(8'h0c, 8'hff);
		// timer mode, bypassed, 8-bit
		wr(8'h0c, 8'hc8);
		wr(8'h00, 8'h10);
		rd(8'h00, 8'h10);
		rd(8'h00, 8'h13);
		wr(8'h00, 8'hfd);
		rd(8'h08, 8'h00);
		rd(8'h08, 8'h04);
		wr(8'h08, 8'h00);
		// 16-bit wrap through the buffer
		wr(8'h0c, 8'h88);
		wr(8'h04, 8'hff);
		wr(8'h00, 8'hfe);
		rd(8'h00, 8'hfe);
		rd(8'h04, 8'hff);
		rd(8'h08, 8'h04);
		rd(8'h00, 8'h07);
		rd(8'h04, 8'h00);
		slp <= 1'b1;
		wr(8'h00, 8'h50);
		rd(8'h00, 8'h50);
		wr(8'h08, 8'h84);
		check({31'h0, irq}, 32'h0);
		wr(8'h08, 8'ha4);
		check({31'h0, irq}, 32'h1);
		wr(8'h08, 8'h00);
		slp <= 1'b0;
		wr(8'h0c, 8'h48);
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h40);
		rd(8'h00, 8'h40);
		// four steps over four prescaled periods
		for (int n = 0; n < 8; n++) begin
			wr(8'h0c, {5'h18, n[2:0]});
			bus(1'b0, 8'h00, 4'hf, 8'h00);
			v = q[7:0];
			repeat ((8 << n) - 3) @(posedge clk);
			bus(1'b0, 8'h00, 4'hf, 8'h00);
			dv = q[7:0] - v;
			check({24'h0, dv}, 32'h4);
		end
		wr(8'h00, 8'h00);
		repeat (200) @(posedge clk);
		wr(8'h00, 8'h00);
		repeat (150) @(posedge clk);
		rd(8'h00, 8'h00);
		// counter mode, rising then falling edge
		for (int e = 0; e < 2; e++) begin
			wr(8'h0c, {3'h7, e[0], 4'h8});
			wr(8'h00, 8'h00);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (8) @(posedge clk);
			rd(8'h00, {7'h0, ~e[0]});
			while (busy) @(posedge clk);
			repeat (8) @(posedge clk);
			rd(8'h00, 8'h01);
		end
		report_and_stop();
	end
endmodule
